// *** common/serial_port_pkg.sv ***
// constants, field layout and state types for the serial port receiver and sleep slave
package serial_port_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [2:0] OFF_RX_CTRL = 3'h0;
  localparam logic [2:0] OFF_TX_CTRL = 3'h1;
  localparam logic [2:0] OFF_RX_DATA = 3'h2;
  localparam logic [2:0] OFF_TX_HOLD = 3'h3;
  localparam logic [2:0] OFF_BAUD_LO = 3'h4;
  localparam logic [2:0] OFF_BAUD_HI = 3'h5;
  localparam logic [2:0] OFF_INT = 3'h6;
  // receive control and status fields
  localparam int B_PORT_EN = 7;
  localparam int B_RX9 = 6;
  localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int B_ADDRESS_DETECTION_ENABLE = 3;
  localparam int B_FERR = 2;
  localparam int B_OVERRUN_ERROR_FLAG = 1;
  localparam int B_RX9D = 0;
  // transmit control fields
  localparam int B_TXEN = 5;
  localparam int B_SYNC = 4;
  localparam int B_WIDE = 3;
  localparam int B_HSPD = 2;
  localparam int B_TSR_IDLE = 1;
  // interrupt register fields
  localparam int B_PERIPHERAL_INTERRUPT_ENABLE = 6;
  localparam int B_RECEIVE_FLAG = 5;
  localparam int B_TRANSMIT_FLAG = 4;
  localparam int B_RECEIVE_INTERRUPT_ENABLE = 1;
  localparam int B_TRANSMIT_INTERRUPT_ENABLE = 0;
  // reset values, oversampling counts and character lengths
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] TX_HOLD_RST = 8'h00;
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_FAST = 5'h04;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// *** common/baud_if.sv ***
// divisor settings and tick between the port and its baud counter
`timescale 1ns/1ns
interface baud_if;
  logic [15:0] divisor;
  logic wide;
  logic restart;
  logic run;
  logic tick;
  modport gen (input divisor, input wide, input restart, input run, output tick);
  modport user (output divisor, output wide, output restart, output run, input tick);
endinterface

// *** rtl/pin_sync.sv ***
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // the data pin idles high, so reset both pins to the high level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '1;
      q <= '1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// *** rtl/baud_counter.sv ***
// baud tick counter with restart and 8- or 16-bit divisor
`timescale 1ns/1ns
module baud_counter (
  input wire logic clk,
  input wire logic sys_rst,
  baud_if.gen bif
);
  logic [15:0] cnt_r;
  logic tick_r;
  wire [15:0] limit = bif.wide ? bif.divisor : {8'h00, bif.divisor[7:0]};
  wire at_limit = (cnt_r == limit);

  always_ff @(posedge clk) begin
    if (sys_rst || bif.restart || !bif.run) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= at_limit ? 16'h0000 : cnt_r + 16'h0001;
      tick_r <= at_limit;
    end
  end

  assign bif.tick = tick_r;
endmodule

// *** rtl/serial_port.sv ***
// serial port receiver, synchronous slave shifter and register file
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module serial_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic sleep_mode,
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe,
  input wire logic clock_pin_in,
  output logic rx_irq,
  output logic tx_irq,
  output logic wake
);
  function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] off);
    return strobe && (a == off);
  endfunction

  // control registers
  logic port_enable_r, ninth_bit_receive_select_r, continuous_receive_enable_r, address_detection_enable_r;
  logic sync_mode_r, txen_r, high_speed_baud_select_r, wide_divisor_select_r;
  logic receive_interrupt_enable_r, transmit_interrupt_enable_r, peripheral_interrupt_enable_r;
  logic [7:0] baud_divisor_low_r, baud_divisor_high_r, rdata_r;
  // receive state
  serial_port_pkg::rx_state_t state_r, state_nxt;
  logic [4:0] tick_cnt_r, tick_cnt_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [8:0] rsr_r, rsr_nxt, rx_buf_r;
  logic rx_done, ferr_nxt, rx_ferr_r, rx_full_r, overrun_error_flag_r;
  // transmit state
  logic [7:0] thr_r, tsr_r;
  logic thr_full_r, tsr_busy_r, dout_r;
  logic [2:0] tx_bit_r;
  logic ck_s, dt_s, ck_d_r;

  baud_if bif ();

  pin_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({clock_pin_in, data_pin_in}),
    .q({ck_s, dt_s})
  );

  baud_counter u_baud (
    .clk(clk),
    .sys_rst(sys_rst),
    .bif(bif)
  );

  // bus decode
  wire wr_rx_ctrl = hit(wr_en, addr, serial_port_pkg::OFF_RX_CTRL);
  wire wr_tx_ctrl = hit(wr_en, addr, serial_port_pkg::OFF_TX_CTRL);
  wire wr_thr = hit(wr_en, addr, serial_port_pkg::OFF_TX_HOLD);
  wire wr_blo = hit(wr_en, addr, serial_port_pkg::OFF_BAUD_LO);
  wire wr_bhi = hit(wr_en, addr, serial_port_pkg::OFF_BAUD_HI);
  wire wr_int = hit(wr_en, addr, serial_port_pkg::OFF_INT);
  wire rd_data = hit(rd_en, addr, serial_port_pkg::OFF_RX_DATA);

  // mode decode
  wire slave_active = port_enable_r && sync_mode_r;
  // async logic stops in sleep: its baud clock would be gone
  wire async_run = port_enable_r && !sync_mode_r && !sleep_mode;
  wire rx_on = port_enable_r && continuous_receive_enable_r && !overrun_error_flag_r;
  wire [3:0] nbits = ninth_bit_receive_select_r ? serial_port_pkg::BITS_9 : serial_port_pkg::BITS_8;
  wire [4:0] ovs = high_speed_baud_select_r ? serial_port_pkg::OVS_FAST : serial_port_pkg::OVS_NORMAL;
  wire [4:0] half_ovs = {1'b0, ovs[4:1]};
  wire ck_rise = ck_s && !ck_d_r;
  wire ck_fall = !ck_s && ck_d_r;

  assign bif.divisor = {baud_divisor_high_r, baud_divisor_low_r};
  assign bif.wide = wide_divisor_select_r;
  assign bif.restart = wr_blo;
  assign bif.run = async_run;

  // receive shifter: external clock in slave mode, oversampled in async mode
  always_comb begin
    state_nxt = state_r;
    tick_cnt_nxt = tick_cnt_r;
    bit_cnt_nxt = bit_cnt_r;
    rsr_nxt = rsr_r;
    rx_done = 1'b0;
    ferr_nxt = 1'b0;
    if (!rx_on) begin
      state_nxt = serial_port_pkg::RX_IDLE;
      bit_cnt_nxt = 4'h0;
    end else if (sync_mode_r) begin
      if (ck_rise) begin
        rsr_nxt = {dt_s, rsr_r[8:1]};
        if (bit_cnt_r == nbits - 4'h1) begin
          rx_done = 1'b1;
          bit_cnt_nxt = 4'h0;
        end else begin
          bit_cnt_nxt = bit_cnt_r + 4'h1;
        end
      end
    end else if (bif.tick) begin
      unique case (state_r)
        serial_port_pkg::RX_IDLE: begin
          if (!dt_s) begin
            state_nxt = serial_port_pkg::RX_START;
            tick_cnt_nxt = 5'h00;
          end
        end
        serial_port_pkg::RX_START: begin
          if (tick_cnt_r == half_ovs - 5'h01) begin
            // a start bit that is gone at mid-bit was noise
            state_nxt = dt_s ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
            tick_cnt_nxt = 5'h00;
            bit_cnt_nxt = 4'h0;
          end else begin
            tick_cnt_nxt = tick_cnt_r + 5'h01;
          end
        end
        serial_port_pkg::RX_DATA: begin
          if (tick_cnt_r == ovs - 5'h01) begin
            tick_cnt_nxt = 5'h00;
            rsr_nxt = {dt_s, rsr_r[8:1]};
            if (bit_cnt_r == nbits - 4'h1) begin
              state_nxt = serial_port_pkg::RX_STOP;
            end else begin
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
          end else begin
            tick_cnt_nxt = tick_cnt_r + 5'h01;
          end
        end
        serial_port_pkg::RX_STOP: begin
          if (tick_cnt_r == ovs - 5'h01) begin
            rx_done = 1'b1;
            ferr_nxt = !dt_s;
            state_nxt = serial_port_pkg::RX_IDLE;
            // slave receive shares this counter, so it must start from zero
            bit_cnt_nxt = 4'h0;
          end else begin
            tick_cnt_nxt = tick_cnt_r + 5'h01;
          end
        end
      endcase
    end
  end

  // lsb first: an eight-bit word sits in the top eight bits of the shifter
  wire [8:0] rx_word = ninth_bit_receive_select_r ? rsr_r_done_align(rsr_nxt, 1'b1) : rsr_r_done_align(rsr_nxt, 1'b0);

  function automatic logic [8:0] rsr_r_done_align(input logic [8:0] s, input logic nine);
    return nine ? s : {1'b0, s[8:1]};
  endfunction

  wire rx_keep = !(address_detection_enable_r && ninth_bit_receive_select_r && !rx_word[8]);
  wire rx_room = !rx_full_r || rd_data;
  wire rx_load = rx_done && rx_keep && rx_room;
  wire ovr_set = rx_done && rx_keep && !rx_room;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= serial_port_pkg::RX_IDLE;
      tick_cnt_r <= 5'h00;
      bit_cnt_r <= 4'h0;
      rsr_r <= 9'h000;
      ck_d_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rsr_r <= rsr_nxt;
      ck_d_r <= ck_s;
    end
  end

  // receive buffer; a new character wins over a read in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_buf_r <= 9'h000;
      rx_ferr_r <= 1'b0;
      rx_full_r <= 1'b0;
      overrun_error_flag_r <= 1'b0;
    end else begin
      if (rx_load) begin
        rx_buf_r <= rx_word;
        rx_ferr_r <= ferr_nxt;
      end
      rx_full_r <= rx_load || (rx_full_r && !rd_data);
      overrun_error_flag_r <= ovr_set || (overrun_error_flag_r && continuous_receive_enable_r);
    end
  end

  // slave transmitter: master samples on rising clock, device moves on falling
  wire tx_on = slave_active && txen_r;
  wire tx_last = tsr_busy_r && ck_fall && (tx_bit_r == 3'h7);
  wire tx_load = tx_on && thr_full_r && (!tsr_busy_r || tx_last);
  wire tx_shift = tsr_busy_r && ck_fall && !tx_last;

  always_ff @(posedge clk) begin
    if (sys_rst || !tx_on) begin
      tsr_r <= 8'h00;
      tsr_busy_r <= 1'b0;
      tx_bit_r <= 3'h0;
      dout_r <= 1'b1;
    end else if (tx_load) begin
      tsr_r <= thr_r;
      tsr_busy_r <= 1'b1;
      tx_bit_r <= 3'h0;
      dout_r <= thr_r[0];
    end else if (tx_last) begin
      tsr_busy_r <= 1'b0;
      dout_r <= 1'b1;
    end else if (tx_shift) begin
      tsr_r <= {1'b0, tsr_r[7:1]};
      tx_bit_r <= tx_bit_r + 3'h1;
      dout_r <= tsr_r[1];
    end
  end

  // a write refills the holding register even as it empties into the shifter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      thr_r <= serial_port_pkg::TX_HOLD_RST;
      thr_full_r <= 1'b0;
    end else begin
      if (wr_thr) begin
        thr_r <= wdata;
      end
      thr_full_r <= wr_thr || (thr_full_r && !tx_load);
    end
  end

  // software registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_enable_r <= 1'b0;
      ninth_bit_receive_select_r <= 1'b0;
      continuous_receive_enable_r <= 1'b0;
      address_detection_enable_r <= 1'b0;
      sync_mode_r <= 1'b0;
      txen_r <= 1'b0;
      high_speed_baud_select_r <= 1'b0;
      wide_divisor_select_r <= 1'b0;
      receive_interrupt_enable_r <= 1'b0;
      transmit_interrupt_enable_r <= 1'b0;
      peripheral_interrupt_enable_r <= 1'b0;
      baud_divisor_low_r <= serial_port_pkg::BAUD_RST;
      baud_divisor_high_r <= serial_port_pkg::BAUD_RST;
    end else begin
      if (wr_rx_ctrl) begin
        port_enable_r <= wdata[serial_port_pkg::B_PORT_EN];
        ninth_bit_receive_select_r <= wdata[serial_port_pkg::B_RX9];
        continuous_receive_enable_r <= wdata[serial_port_pkg::B_CONTINUOUS_RECEIVE_ENABLE];
        address_detection_enable_r <= wdata[serial_port_pkg::B_ADDRESS_DETECTION_ENABLE];
      end
      if (wr_tx_ctrl) begin
        txen_r <= wdata[serial_port_pkg::B_TXEN];
        sync_mode_r <= wdata[serial_port_pkg::B_SYNC];
        wide_divisor_select_r <= wdata[serial_port_pkg::B_WIDE];
        high_speed_baud_select_r <= wdata[serial_port_pkg::B_HSPD];
      end
      if (wr_int) begin
        peripheral_interrupt_enable_r <= wdata[serial_port_pkg::B_PERIPHERAL_INTERRUPT_ENABLE];
        receive_interrupt_enable_r <= wdata[serial_port_pkg::B_RECEIVE_INTERRUPT_ENABLE];
        transmit_interrupt_enable_r <= wdata[serial_port_pkg::B_TRANSMIT_INTERRUPT_ENABLE];
      end
      if (wr_blo) begin
        baud_divisor_low_r <= wdata;
      end
      if (wr_bhi) begin
        baud_divisor_high_r <= wdata;
      end
    end
  end

  // read mux
  wire ninth_shown = address_detection_enable_r || rx_buf_r[8];
  wire [7:0] rx_ctrl_rd = {port_enable_r, ninth_bit_receive_select_r, 1'b0, continuous_receive_enable_r,
                           address_detection_enable_r, rx_ferr_r, overrun_error_flag_r, ninth_shown};
  wire [7:0] tx_ctrl_rd = {2'b00, txen_r, sync_mode_r, wide_divisor_select_r, high_speed_baud_select_r,
                           !tsr_busy_r, 1'b0};
  wire [7:0] int_rd = {1'b0, peripheral_interrupt_enable_r, rx_full_r, !thr_full_r, 2'b00,
                       receive_interrupt_enable_r, transmit_interrupt_enable_r};
  wire [7:0] rd_mux = (addr == serial_port_pkg::OFF_RX_CTRL) ? rx_ctrl_rd :
                      (addr == serial_port_pkg::OFF_TX_CTRL) ? tx_ctrl_rd :
                      (addr == serial_port_pkg::OFF_RX_DATA) ? rx_buf_r[7:0] :
                      (addr == serial_port_pkg::OFF_TX_HOLD) ? thr_r :
                      (addr == serial_port_pkg::OFF_BAUD_LO) ? baud_divisor_low_r :
                      (addr == serial_port_pkg::OFF_BAUD_HI) ? baud_divisor_high_r :
                      (addr == serial_port_pkg::OFF_INT) ? int_rd : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_en ? rd_mux : 8'h00;
    end
  end

  assign rdata = rdata_r;
  assign data_pin_out = dout_r;
  assign data_pin_oe = tx_on && !continuous_receive_enable_r;
  assign rx_irq = rx_full_r && receive_interrupt_enable_r;
  assign tx_irq = !thr_full_r && transmit_interrupt_enable_r;
  // wake needs the peripheral gate as well as the event's own enable
  assign wake = sleep_mode && peripheral_interrupt_enable_r && (rx_irq || tx_irq);

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence rd_data_s;
    rd_data && !rx_load;
  endsequence
  sequence async_sleep_s;
    sleep_mode && !sync_mode_r ##1 sleep_mode && !sync_mode_r;
  endsequence

  rx_flag_set_a: assert property (rx_load |=> rx_full_r && rx_buf_r == $past(rx_word))
    else $error("buffer load did not raise receive flag");
  rx_nine_bits_a: assert property (rx_done && !sync_mode_r |-> bit_cnt_r == nbits - 4'h1)
    else $error("character length does not follow ninth-bit select");
  rx_enable_gate_a: assert property (!continuous_receive_enable_r |-> !rx_load)
    else $error("character accepted with receive disabled");
  rd_data_value_a: assert property (rd_data |=> rdata == $past(rx_buf_r[7:0]))
    else $error("data read returned wrong byte");
  overrun_error_flag_clear_a: assert property ($fell(overrun_error_flag_r) |-> $past(!continuous_receive_enable_r))
    else $error("overrun cleared without receive disable");
  addr_discard_a: assert property (rx_done && address_detection_enable_r && ninth_bit_receive_select_r
                                   && !rx_word[8] |=> !rx_full_r || $stable(rx_buf_r))
    else $error("non-address character entered buffer");
  addr_ninth_a: assert property (hit(rd_en, addr, serial_port_pkg::OFF_RX_CTRL) && address_detection_enable_r
                                 |=> rdata[serial_port_pkg::B_RX9D])
    else $error("ninth bit not one in address mode");
  sleep_halt_a: assert property (async_sleep_s |-> !bif.tick && (!rx_on || state_nxt == state_r))
    else $error("async logic ran during sleep");
  slave_edge_a: assert property (rx_done && sync_mode_r |-> ck_rise)
    else $error("slave word completed without clock edge");
  rx_wake_a: assert property (rx_load && sleep_mode && peripheral_interrupt_enable_r && receive_interrupt_enable_r
                              && $stable(sleep_mode) |=> wake)
    else $error("received word did not wake");
  rd_empty_a: assert property (rd_data_s |=> !rx_full_r)
    else $error("receive flag stayed after last unload");
  tx_move_a: assert property (tx_last && thr_full_r && !wr_thr |=> tsr_busy_r && !thr_full_r
                              && tsr_r == $past(thr_r))
    else $error("holding byte did not move to shifter");
  tx_write_a: assert property (wr_thr |=> thr_full_r && !tx_irq)
    else $error("write did not clear transmit flag");
  rx_hold_a: assert property (rx_full_r && !rx_load |=> $stable(rx_buf_r))
    else $error("buffered character changed while shifting");
  baud_restart_a: assert property (wr_blo |=> !bif.tick)
    else $error("baud counter not restarted by low byte write");
  overrun_a: assert property (ovr_set |=> overrun_error_flag_r ##1 !rx_load)
    else $error("overrun not flagged or transfer continued");
endmodule

// *** testbench/remote_station.sv ***
// far-side station: asynchronous sender and clock master for slave mode
`timescale 1ns/1ns
module remote_station (
  output logic data_line,
  output logic data_en,
  output logic clock_line,
  input wire logic data_seen
);
  initial begin
    data_line = 1'b1;
    data_en = 1'b1;
    clock_line = 1'b0;
  end
  // idle high, start low, lsb first, one stop bit high
  task automatic send_char(input logic [8:0] word, input int nbits, input int bit_ns);
    data_line <= 1'b0;
    #(bit_ns);
    for (int i = 0; i < nbits; i++) begin
      data_line <= word[i];
      #(bit_ns);
    end
    data_line <= 1'b1;
    #(bit_ns);
  endtask
  // clock stands low outside words; 64 ns period, device samples rising edge
  task automatic clock_word(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
    data_en <= drive;
    for (int i = 0; i < 8; i++) begin
      if (drive) begin
        data_line <= tx[i];
      end
      #32 clock_line <= 1'b1;
      rx[i] = data_seen;
      #32 clock_line <= 1'b0;
    end
    data_en <= 1'b1;
    data_line <= 1'b1;
  endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the serial port receiver and sleep slave
`timescale 1ns/1ns
module testbench;
  localparam int BIT_NS = 256;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic sleep_mode = 1'b0;
  logic [7:0] rdata;
  logic data_pin_out, data_pin_oe, rx_irq, tx_irq, wake;
  logic data_line, data_en, clock_line, data_pin_in;
  logic [7:0] b, b2, got;
  int err_count = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  // a released line shows the inverse of its last value
  assign data_pin_in = data_pin_oe ? data_pin_out : (data_en ? data_line : ~data_line);
  serial_port i_serial_port (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .sleep_mode(sleep_mode), .data_pin_in(data_pin_in),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .clock_pin_in(clock_line),
    .rx_irq(rx_irq), .tx_irq(tx_irq), .wake(wake));
  remote_station i_remote_station (.data_line(data_line), .data_en(data_en), .clock_line(clock_line),
    .data_seen(data_pin_in));
  function automatic logic [7:0] int_val(input int pe, input int rf, input int tf, input int re,
      input int te);
    logic [7:0] v;
    v = 8'h00;
    v[serial_port_pkg::B_PERIPHERAL_INTERRUPT_ENABLE] = pe[0];
    v[serial_port_pkg::B_RECEIVE_FLAG] = rf[0];
    v[serial_port_pkg::B_TRANSMIT_FLAG] = tf[0];
    v[serial_port_pkg::B_RECEIVE_INTERRUPT_ENABLE] = re[0];
    v[serial_port_pkg::B_TRANSMIT_INTERRUPT_ENABLE] = te[0];
    return v;
  endfunction
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // gap cycle after each strobe so no strobe is assigned twice in one step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(what, exp, rdata);
    @(posedge clk);
  endtask
  task automatic wait_hi(input int which, input string what);
    int k;
    k = 0;
    @(posedge clk);
    while (((which == 0) ? rx_irq : wake) !== 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    n_tests++;
    if (k == 2000) begin
      err_count++;
      $display("BAD %s expected 1 seen timeout", what);
      results();
    end
  endtask
  initial begin
    b = 8'($urandom(32'h0df9));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(serial_port_pkg::OFF_RX_CTRL, 8'h00, "rx_ctrl reset");
    rd(serial_port_pkg::OFF_INT, int_val(0, 0, 1, 0, 0), "int reset");
    rd(3'h7, 8'h00, "unmapped");
    $display("test reset done");
    wr(serial_port_pkg::OFF_BAUD_HI, 8'h00);
    wr(serial_port_pkg::OFF_BAUD_LO, 8'h01);
    wr(serial_port_pkg::OFF_INT, int_val(0, 0, 0, 1, 0));
    wr(serial_port_pkg::OFF_RX_CTRL, 8'h90);
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      i_remote_station.send_char({1'b0, b}, 8, BIT_NS);
      wait_hi(0, "rx_irq");
      rd(serial_port_pkg::OFF_INT, int_val(0, 1, 1, 1, 0), "flag set");
      rd(serial_port_pkg::OFF_RX_DATA, b, "rx data");
      rd(serial_port_pkg::OFF_INT, int_val(0, 0, 1, 1, 0), "flag clear");
    end
    $display("test async receive done");
    wr(serial_port_pkg::OFF_TX_CTRL, 8'h0c);
    wr(serial_port_pkg::OFF_BAUD_LO, 8'h07);
    b = 8'($urandom);
    i_remote_station.send_char({1'b0, b}, 8, BIT_NS);
    wait_hi(0, "fast flag");
    rd(serial_port_pkg::OFF_RX_DATA, b, "fast data");
    wr(serial_port_pkg::OFF_TX_CTRL, 8'h00);
    wr(serial_port_pkg::OFF_BAUD_LO, 8'h01);
    $display("test fast wide divisor done");
    b = 8'($urandom);
    b2 = ~b;
    i_remote_station.send_char({1'b0, b}, 8, BIT_NS);
    i_remote_station.send_char({1'b0, b2}, 8, BIT_NS);
    @(posedge clk);
    rd(serial_port_pkg::OFF_RX_CTRL, 8'h92, "overrun set");
    rd(serial_port_pkg::OFF_RX_DATA, b, "kept data");
    wr(serial_port_pkg::OFF_RX_CTRL, 8'h80);
    rd(serial_port_pkg::OFF_RX_CTRL, 8'h80, "overrun clear");
    i_remote_station.send_char({1'b0, b}, 8, BIT_NS);
    repeat (40) @(posedge clk);
    rd(serial_port_pkg::OFF_INT, int_val(0, 0, 1, 1, 0), "receive off");
    $display("test overrun done");
    wr(serial_port_pkg::OFF_RX_CTRL, 8'hd8);
    i_remote_station.send_char({1'b0, b}, 9, BIT_NS);
    repeat (40) @(posedge clk);
    rd(serial_port_pkg::OFF_INT, int_val(0, 0, 1, 1, 0), "data dropped");
    i_remote_station.send_char({1'b1, b2}, 9, BIT_NS);
    wait_hi(0, "address flag");
    rd(serial_port_pkg::OFF_RX_CTRL, 8'hd9, "ninth bit");
    rd(serial_port_pkg::OFF_RX_DATA, b2, "address byte");
    wr(serial_port_pkg::OFF_RX_CTRL, 8'hd0);
    i_remote_station.send_char({1'b0, b}, 9, BIT_NS);
    wait_hi(0, "data flag");
    rd(serial_port_pkg::OFF_RX_CTRL, 8'hd0, "ninth zero");
    rd(serial_port_pkg::OFF_RX_DATA, b, "data byte");
    $display("test address detection done");
    wr(serial_port_pkg::OFF_RX_CTRL, 8'h90);
    sleep_mode <= 1'b1;
    i_remote_station.send_char({1'b0, b}, 8, BIT_NS);
    repeat (40) @(posedge clk);
    rd(serial_port_pkg::OFF_INT, int_val(0, 0, 1, 1, 0), "async asleep");
    sleep_mode <= 1'b0;
    $display("test async sleep done");
    wr(serial_port_pkg::OFF_TX_CTRL, 8'h10);
    wr(serial_port_pkg::OFF_INT, int_val(1, 0, 0, 1, 0));
    sleep_mode <= 1'b1;
    i_remote_station.clock_word(b2, 1'b1, got);
    wait_hi(1, "rx wake");
    rd(serial_port_pkg::OFF_RX_DATA, b2, "slave rx");
    rd(serial_port_pkg::OFF_INT, int_val(1, 0, 1, 1, 0), "slave flag");
    sleep_mode <= 1'b0;
    $display("test slave receive done");
    wr(serial_port_pkg::OFF_RX_CTRL, 8'h80);
    wr(serial_port_pkg::OFF_TX_CTRL, 8'h30);
    wr(serial_port_pkg::OFF_INT, int_val(1, 0, 0, 0, 1));
    wr(serial_port_pkg::OFF_TX_HOLD, b);
    wr(serial_port_pkg::OFF_TX_HOLD, b2);
    rd(serial_port_pkg::OFF_INT, int_val(1, 0, 0, 0, 1), "tx flag clear");
    chk("oe", 8'h01, {7'h00, data_pin_oe});
    sleep_mode <= 1'b1;
    i_remote_station.clock_word(8'h00, 1'b0, got);
    chk("tx word", b, got);
    wait_hi(1, "tx wake");
    rd(serial_port_pkg::OFF_INT, int_val(1, 0, 1, 0, 1), "tx flag set");
    i_remote_station.clock_word(8'h00, 1'b0, got);
    chk("next word", b2, got);
    sleep_mode <= 1'b0;
    $display("test slave transmit done");
    results();
  end
endmodule
